// File: design/acs_pkg.sv
// Constants, register map and carrier types of the conversion sequencer.
// Assumes a 32-bit AHB-Lite register bus on a single system clock.
package acs_pkg;
  // Register byte offsets.
  localparam logic [7:0] OFS_CTL0 = 8'h00;
  localparam logic [7:0] OFS_CTL1 = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_RSLT = 8'h20;
  // Control register zero fields.
  localparam int DIV_LSB = 0;
  localparam int FSEL_LSB = 5;
  localparam int TEN_BIT = 7;
  localparam logic [4:0] DIV_RST = 5'h03;
  localparam logic [4:0] DIV_MIN = 5'h01;
  localparam logic [1:0] FSEL_RST = 2'h0;
  // Control register one fields.
  localparam int CHAN_LSB = 0;
  localparam int EIGHT_BIT = 4;
  localparam int MULTI_BIT = 5;
  localparam int SCAN_BIT = 6;
  // Status register fields.
  localparam int CONVF_LSB = 0;
  localparam int CUR_LSB = 8;
  localparam int BUSY_BIT = 14;
  localparam int SEQF_BIT = 15;
  // Timing in converter clocks.
  localparam logic [4:0] SAMP_TICKS = 5'd4;
  localparam logic [4:0] INIT_TICKS = 5'd2;
  localparam logic [4:0] RES8_TICKS = 5'd10;
  localparam logic [4:0] RES_TEN_TICKS = 5'd12;
  localparam logic [3:0] BITS8 = 4'd8;
  localparam logic [3:0] BITS10 = 4'd10;
  localparam logic [9:0] MSB8 = 10'h080;
  localparam logic [9:0] MSB10 = 10'h200;
  localparam logic [2:0] LAST4 = 3'd3;
  localparam logic [2:0] LAST8 = 3'd7;
  // Bus encodings.
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef enum logic [1:0] {PH_NONE, PH_INIT, PH_XFER, PH_FINAL} acs_phase_t;

  typedef struct packed {
    logic act;
    logic wr;
    logic [7:0] addr;
  } acs_aphase_t;

  typedef struct packed {
    logic [3:0] chan;
    logic eight;
    logic multi;
    logic scan;
  } acs_ctl1_t;

  typedef struct packed {
    logic [4:0] div;
    logic [1:0] fsel;
    logic ten;
  } acs_ctl0_t;

  function automatic logic [4:0] acs_final_ticks(input logic [1:0] fsel);
    acs_final_ticks = 5'd2 << fsel;
  endfunction : acs_final_ticks
endpackage : acs_pkg

// File: design/acs_top.sv
// Conversion sequencer: prescaler, sample timing, approximation register,
// mode control, result slots and flags, reached over AHB-Lite.
// Assumes a single bus master and a comparator output synchronous to hclk.
`timescale 1ns/1ns
module acs_top #(
  parameter int RES_W = 10
) (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Analog front end.
  input wire logic comp_hi,
  output logic adc_clk,
  output logic [3:0] mux_sel,
  output acs_pkg::acs_phase_t sample_phase,
  output logic [9:0] approximation
);
  import acs_pkg::*;

  if (RES_W != 10)
  begin : g_bad_width
    $error("RES_W must be 10");
  end

  typedef enum logic [1:0] {ST_IDLE, ST_SAMP, ST_FINAL, ST_RES} acs_state_t;

  // Bus state.
  acs_aphase_t ap_q;
  logic [31:0] rdata_q;
  // Registers.
  acs_ctl0_t ctl0_q;
  acs_ctl1_t ctl1_q;
  logic [7:0] convf_q, convf_d;
  logic seqf_q, seqf_d;
  logic [9:0] rslt_q [8];
  // Prescaler.
  logic [4:0] pc_q, pc_d;
  logic half_q;
  // Sequencer.
  acs_state_t st_q, st_d;
  logic [4:0] cnt_q, cnt_d;
  logic [2:0] idx_q, idx_d;
  logic [9:0] appr_q, appr_d;
  logic [3:0] mux_q;
  acs_phase_t ph_q, ph_d;

  // Address phase decode.
  wire take = hsel && htrans[1] && hready;
  wire word = (hsize == HSIZE_WORD);
  wire a_ctl0 = (haddr == OFS_CTL0);
  wire a_ctl1 = (haddr == OFS_CTL1);
  wire a_stat = (haddr == OFS_STAT);
  wire a_rslt = (haddr[7:5] == OFS_RSLT[7:5]) && (haddr[1:0] == 2'h0);
  wire [2:0] a_slot = haddr[4:2];
  // Data phase write strobes.
  wire dw = ap_q.act && ap_q.wr;
  wire wr_ctl0 = dw && (ap_q.addr == OFS_CTL0);
  wire wr_ctl1 = dw && (ap_q.addr == OFS_CTL1);
  wire wr_ctl = wr_ctl0 || wr_ctl1;

  // Status view.
  wire busy = (st_q != ST_IDLE);
  wire [31:0] stat_word = {16'h0000, seqf_q, busy, 2'h0, mux_q, convf_q};
  wire [31:0] ctl0_word = {24'h000000, ctl0_q.ten, ctl0_q.fsel, ctl0_q.div};
  wire [31:0] ctl1_word = {25'h0, ctl1_q.scan, ctl1_q.multi, ctl1_q.eight,
                           ctl1_q.chan};
  wire [31:0] rd_mux = a_ctl0 ? ctl0_word :
                       a_ctl1 ? ctl1_word :
                       a_stat ? stat_word :
                       a_rslt ? {22'h0, rslt_q[a_slot]} : 32'h00000000;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ap_q <= '0;
      rdata_q <= 32'h00000000;
    end
    else
    begin
      ap_q <= '{act: take && word, wr: hwrite, addr: haddr};
      rdata_q <= (take && word && !hwrite) ? rd_mux : 32'h00000000;
    end
  end

  // Control registers take the data phase word; any control one write starts.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctl0_q <= '{div: DIV_RST, fsel: FSEL_RST, ten: 1'b0};
      ctl1_q <= '0;
    end
    else
    begin
      if (wr_ctl0)
      begin
        ctl0_q <= '{div: hwdata[DIV_LSB +: 5], fsel: hwdata[FSEL_LSB +: 2],
                    ten: hwdata[TEN_BIT]};
      end
      if (wr_ctl1)
      begin
        ctl1_q <= '{chan: hwdata[CHAN_LSB +: 4], eight: hwdata[EIGHT_BIT],
                    multi: hwdata[MULTI_BIT], scan: hwdata[SCAN_BIT]};
      end
    end
  end

  // Prescaler: modulus stage of code plus one, then a toggle stage.
  // Code zero is reserved and runs as code one, so a period is never
  // shorter than four bus clocks.
  wire [4:0] div_eff = (ctl0_q.div < DIV_MIN) ? DIV_MIN : ctl0_q.div;
  wire pc_wrap = (pc_q >= div_eff);
  wire tick = pc_wrap && half_q;
  assign pc_d = pc_wrap ? 5'd0 : pc_q + 5'd1;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pc_q <= 5'd0;
      half_q <= 1'b0;
    end
    else
    begin
      pc_q <= pc_d;
      half_q <= half_q ^ pc_wrap;
    end
  end

  // Mode decode: the mode number is {scan, multi_channel_select, eight_conversion_select}.
  wire [2:0] mode = {ctl1_q.scan, ctl1_q.multi, ctl1_q.eight};
  wire [2:0] last_idx = mode[0] ? LAST8 : LAST4;
  wire [4:0] fin_ticks = acs_final_ticks(ctl0_q.fsel);
  wire [4:0] res_ticks = ctl0_q.ten ? RES_TEN_TICKS : RES8_TICKS;
  wire [3:0] nbits = ctl0_q.ten ? BITS10 : BITS8;
  wire [9:0] msb_mask = ctl0_q.ten ? MSB10 : MSB8;
  // Multi-channel modes replace the low channel bits by the conversion index.
  wire [3:0] chan_eff = !mode[1] ? ctl1_q.chan :
                        mode[0] ? {ctl1_q.chan[3], idx_q} :
                        {ctl1_q.chan[3:2], idx_q[1:0]};
  wire samp_end = tick && (st_q == ST_SAMP) && (cnt_q == SAMP_TICKS - 5'd1);
  wire fin_end = tick && (st_q == ST_FINAL) && (cnt_q == fin_ticks - 5'd1);
  wire conv_done = tick && (st_q == ST_RES) && (cnt_q == res_ticks - 5'd1);
  wire seq_done = conv_done && (idx_q == last_idx);
  wire [3:0] bitpos = nbits - cnt_q[3:0];

  // Sequencer next state; control writes override the running sequence.
  always_comb
  begin
    st_d = st_q;
    cnt_d = cnt_q;
    idx_d = idx_q;
    if (tick && busy)
    begin
      cnt_d = cnt_q + 5'd1;
    end
    unique case (st_q)
      ST_IDLE:
      begin
        cnt_d = 5'd0;
      end
      ST_SAMP:
      begin
        if (samp_end)
        begin
          st_d = ST_FINAL;
          cnt_d = 5'd0;
        end
      end
      ST_FINAL:
      begin
        if (fin_end)
        begin
          st_d = ST_RES;
          cnt_d = 5'd0;
        end
      end
      ST_RES:
      begin
        if (conv_done)
        begin
          cnt_d = 5'd0;
          idx_d = idx_q + 3'd1;
          st_d = ST_SAMP;
          if (seq_done)
          begin
            idx_d = 3'd0;
            st_d = ctl1_q.scan ? ST_SAMP : ST_IDLE;
          end
        end
      end
    endcase
    if (wr_ctl)
    begin
      cnt_d = 5'd0;
      idx_d = 3'd0;
      st_d = wr_ctl1 ? ST_SAMP : ST_IDLE;
    end
  end

  // Approximation register: MSB set first, then one bit per clock downward.
  always_comb
  begin
    appr_d = appr_q;
    if (tick && (st_q == ST_RES))
    begin
      if (cnt_q == 5'd0)
      begin
        appr_d = msb_mask;
      end
      else if (cnt_q <= {1'b0, nbits})
      begin
        for (int i = 0; i < 10; i++)
        begin
          if ((4'(i) == bitpos) && comp_hi)
          begin
            appr_d[i] = 1'b0;
          end
          if ((4'(i + 1) == bitpos))
          begin
            appr_d[i] = 1'b1;
          end
        end
      end
    end
  end

  // Flags: a completion in the same cycle as an abort still sets its flag.
  always_comb
  begin
    convf_d = wr_ctl ? 8'h00 : convf_q;
    seqf_d = wr_ctl ? 1'b0 : seqf_q;
    if (conv_done)
    begin
      convf_d[idx_q] = 1'b1;
    end
    if (seq_done)
    begin
      seqf_d = 1'b1;
    end
  end

  always_comb
  begin
    unique case (st_d)
      ST_SAMP: ph_d = (cnt_d < INIT_TICKS) ? PH_INIT : PH_XFER;
      ST_FINAL: ph_d = PH_FINAL;
      default: ph_d = PH_NONE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_q <= ST_IDLE;
      cnt_q <= 5'd0;
      idx_q <= 3'd0;
      appr_q <= 10'h000;
      convf_q <= 8'h00;
      seqf_q <= 1'b0;
      mux_q <= 4'h0;
      ph_q <= PH_NONE;
    end
    else
    begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      idx_q <= idx_d;
      appr_q <= appr_d;
      convf_q <= convf_d;
      seqf_q <= seqf_d;
      mux_q <= chan_eff;
      ph_q <= ph_d;
    end
  end

  // Result slots; an eight-bit result sits in the low bits.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int i = 0; i < 8; i++)
      begin
        rslt_q[i] <= 10'h000;
      end
    end
    else if (conv_done)
    begin
      rslt_q[idx_q] <= appr_q;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_q;
  assign adc_clk = half_q;
  assign mux_sel = mux_q;
  assign sample_phase = ph_q;
  assign approximation = appr_q;

  // Checks.
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic [7:0] gap_q;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      gap_q <= 8'd0;
    end
    else
    begin
      gap_q <= tick ? 8'd0 : ((gap_q == 8'hff) ? gap_q : gap_q + 8'd1);
    end
  end

  a_tick_spacing: assert property (tick |-> gap_q >= 8'd3)
    else $error("converter ticks closer than four bus clocks");
  a_tick_gap: assert property (tick && $past(tick, 4) |-> gap_q >= 8'd3)
    else $error("converter clock shorter than four bus clocks");
  a_samp_len: assert property ((st_q == ST_SAMP) && (st_d == ST_FINAL)
    |-> cnt_q == 5'd3) else $error("initial sample portions not four clocks");
  a_final_len: assert property ((st_q == ST_FINAL) |-> cnt_q < fin_ticks)
    else $error("final sample portion too long");
  a_final_exit: assert property (fin_end && !wr_ctl |=> st_q == ST_RES)
    else $error("final sample did not end into resolution");
  a_res_len: assert property ((st_q == ST_RES) |-> cnt_q < res_ticks)
    else $error("resolution exceeded its clock count");
  a_convf_set: assert property (conv_done |=> convf_q[$past(idx_q)])
    else $error("conversion flag not set on slot write");
  a_seqf_single: assert property (seq_done && !ctl1_q.scan && !wr_ctl
    |=> seqf_q && (st_q == ST_IDLE)) else $error("single sequence did not end");
  a_start_seq: assert property (wr_ctl1 |=> (st_q == ST_SAMP) && (idx_q == 3'd0))
    else $error("control one write did not start a sequence");
  a_halt_ctl0: assert property (wr_ctl0 |=> (st_q == ST_IDLE) ##1
    ((st_q == ST_IDLE) || $past(wr_ctl1))) else $error("control zero write did not halt");
  a_abort_flags: assert property (busy && wr_ctl && !conv_done
    |=> (convf_q == 8'h00) && !seqf_q) else $error("abort left flags set");
  a_multi_chan: assert property (mode[1] && (st_q == ST_FINAL) && !mode[0]
    |-> mux_q[1:0] == idx_q[1:0]) else $error("multi channel index wrong");
  a_appr_start: assert property (tick && (st_q == ST_RES) && (cnt_q == 5'd0)
    |=> appr_q == $past(msb_mask)) else $error("approximation did not start at MSB");

  c_mode0_done: cover property (seq_done && (mode == 3'd0));
  c_mode7_wrap: cover property (seq_done && (mode == 3'd7) ##1 st_q == ST_SAMP);
  c_abort: cover property (busy && wr_ctl0);
  c_ten_bit: cover property (conv_done && ctl0_q.ten);
endmodule : acs_top

// File: tb/acs_analog_model.sv
// Comparator stand-in for the analog front end of the sequencer.
// Assumes 8-bit trials sit in the low byte of the approximation bus.
`timescale 1ns/1ns
module acs_analog_model (
  // Input level of each of the sixteen mux sources.
  input wire logic [15:0][9:0] lvl,
  input wire logic ten_bit,
  // Converter side.
  input wire logic [3:0] mux_sel,
  input wire logic [9:0] approximation,
  output logic comp_hi
);
  logic [9:0] level;

  // An 8-bit trial is weighed against the top eight bits of the level.
  assign level = ten_bit ? lvl[mux_sel] : {2'h0, lvl[mux_sel][9:2]};
  assign comp_hi = approximation > level;
endmodule : acs_analog_model

// File: tb/acs_tb_top.sv
// Self-checking bench for the conversion sequencer, driven over AHB-Lite.
// Assumes hreadyout feeds hready and a comparator model on the analog side.
`timescale 1ns/1ns
module acs_tb_top;
  import acs_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, comp_hi, adc_clk, tenb_m;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rd;
  logic [3:0] mux_sel;
  acs_phase_t sample_phase;
  logic [9:0] approximation;
  logic [15:0][9:0] lvl;
  logic r10;
  int error_cnt, check_count, cyc, s, p, t, n, a, m, i, ch, n8, c;

  acs_top acs_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .comp_hi(comp_hi),
    .adc_clk(adc_clk), .mux_sel(mux_sel), .sample_phase(sample_phase),
    .approximation(approximation));
  acs_analog_model acs_analog_model_inst (.lvl(lvl), .ten_bit(tenb_m), .mux_sel(mux_sel),
    .approximation(approximation), .comp_hi(comp_hi));
  assign hready = hreadyout;

  initial
  begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  task give_verdict;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : give_verdict

  // A hang is cut short well beyond the expected run length.
  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      error_cnt++;
      give_verdict();
    end
  end

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task ahb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= ad;
    hwrite <= wr;
    hsize <= HSIZE_WORD;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb

  task run_len(input int lo, input int hi, output int k);
    k = 0;
    while (!(sample_phase >= lo && sample_phase <= hi)) @(posedge hclk);
    while (sample_phase >= lo && sample_phase <= hi)
    begin
      k++;
      @(posedge hclk);
    end
  endtask : run_len

  function automatic logic [31:0] exp_res(input logic [9:0] l, input logic r);
    exp_res = r ? {22'h0, l} : {24'h0, l[9:2]};
  endfunction : exp_res

  initial
  begin
    {hresetn, hsel, hwrite, tenb_m} = 4'h0;
    {haddr, htrans, hwdata, lvl} = '0;
    hsize = HSIZE_WORD;
    void'($urandom(37820));
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, OFS_CTL0, 32'h0);
    chk("ctl0 reset", 32'h03, rd);
    ahb(1'b1, OFS_STAT, 32'hffff);
    ahb(1'b0, OFS_STAT, 32'h0);
    chk("stat reset", 32'h0, rd);
    ahb(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h0, rd);
    // Tick period and sample portions for every final sample code.
    for (s = 0; s < 4; s++)
    begin
      p = $urandom_range(1, 3);
      t = 2 * (p + 1);
      ahb(1'b1, OFS_CTL0, {24'h0, s[0], s[1:0], p[4:0]});
      ahb(1'b1, OFS_CTL1, $urandom() & 32'hffffff80);
      // Start on a rising edge so that a whole high phase is counted.
      while (adc_clk === 1'b1) @(posedge hclk);
      while (adc_clk !== 1'b1) @(posedge hclk);
      n = 0;
      while (adc_clk === 1'b1)
      begin
        n++;
        @(posedge hclk);
      end
      while (adc_clk !== 1'b1)
      begin
        n++;
        @(posedge hclk);
      end
      chk("adc_clk period", t, n);
      chk("four bus clocks", 1, n >= 4);
      run_len(3, 3, n);
      run_len(0, 0, n);
      chk("resolution", (s[0] ? 12 : 10) * t, n);
      run_len(1, 2, a);
      chk("first portions", 4 * t, a);
      run_len(3, 3, n);
      chk("final sample", (2 << s) * t, n);
      chk("sample period", ((2 << s) + 4) * t, a + n);
    end
    // Every conversion mode with random channel, levels and resolution.
    for (m = 0; m < 8; m++)
    begin
      r10 = 1'($urandom_range(0, 1));
      n8 = m[0] ? 8 : 4;
      // A channel block starts on a multiple of its own length.
      ch = m[1] ? ($urandom_range(0, 15) & (16 - n8)) : $urandom_range(0, 15);
      for (i = 0; i < 16; i++) lvl[i] <= 10'($urandom_range(0, 1023));
      tenb_m <= r10;
      ahb(1'b1, OFS_CTL0, {24'h0, r10, 7'h01});
      ahb(1'b1, OFS_CTL1, {$urandom() & 32'hffffff80} | {25'h0, m[2:0], ch[3:0]});
      while (sample_phase !== PH_FINAL) @(posedge hclk);
      chk("mux_sel", ch, mux_sel);
      do ahb(1'b0, OFS_STAT, 32'h0); while (rd[SEQF_BIT] !== 1'b1);
      chk("conversion flags", n8 == 8 ? 32'hff : 32'h0f, rd[7:0]);
      chk("busy", m[2], rd[BUSY_BIT]);
      if (m[2])
      begin
        for (i = 0; i < 16; i++) lvl[i] <= 10'($urandom_range(0, 1023));
        repeat (2 * n8 * 72 + 50) @(posedge hclk);
      end
      for (i = 0; i < n8; i++)
      begin
        c = m[1] ? ch + i : ch;
        ahb(1'b0, OFS_RSLT + 8'(4 * i), 32'h0);
        chk("slot", exp_res(lvl[c], r10), rd);
      end
      // In scan modes, abort inside a final sample so no conversion lands with the write.
      while (m[2] && sample_phase !== PH_FINAL) @(posedge hclk);
      ahb(1'b1, m[0] ? OFS_CTL1 : OFS_CTL0, {24'h0, r10, 7'h01});
      ahb(1'b0, OFS_STAT, 32'h0);
      chk("flags cleared", 32'h0, rd & 32'h80ff);
      chk("running", m[0], rd[BUSY_BIT]);
      repeat (300) @(posedge hclk);
      ahb(1'b0, OFS_STAT, 32'h0);
      if (!m[0]) chk("halted", 32'h0, rd & 32'hc0ff);
    end
    give_verdict();
  end
endmodule : acs_tb_top
